// ===== core/thermal_pkg.sv
// Constants, register map and carrier types for the die thermal block.
// Assumes a single 10 MHz pclk domain and two cores.
package thermal_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Hot time with throttling engaged before out-of-spec latches
  localparam int unsigned OOS_TIME_NS = 1000000;
  localparam int unsigned OOS_CYCLES = OOS_TIME_NS / CLK_PERIOD_NS;
  // Half period of the clock modulation pattern
  localparam int unsigned MOD_HALF_NS = 800;
  localparam int unsigned MOD_HALF_CYCLES = MOD_HALF_NS / CLK_PERIOD_NS;

  // ==========================================================
  // Sensor scale
  localparam int NUM_CORES = 2;
  localparam logic [7:0] TJ_MAX = 8'h64;
  localparam logic [6:0] TRIP_HYST = 7'h02;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SENSE_OFS [NUM_CORES] = '{8'h04, 8'h08};
  localparam logic [7:0] THRESH_OFS [NUM_CORES] = '{8'h0c, 8'h10};
  localparam logic [7:0] HOTSTAT_OFS = 8'h14;

  // Sense word fields
  localparam int SENSE_VALID_BIT = 8;
  localparam int SENSE_TRIP_BIT = 16;
  localparam int SENSE_OOS_BIT = 17;
  localparam int SENSE_OOS_STICKY_BIT = 18;
  localparam int SENSE_THR1_STICKY_BIT = 19;
  localparam int SENSE_THR2_STICKY_BIT = 20;

  // Hot status word fields
  localparam int HOT_LEVEL_BIT = 0;
  localparam int HOT_EXT_BIT = 1;
  localparam int HOT_RISE_BIT = 2;
  localparam int HOT_FALL_BIT = 3;
  localparam int HOT_OWN_BIT = 4;
  localparam int HOT_PERF_BIT = 5;
  localparam int HOT_GATE_BIT = 6;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {LP_NORMAL, LP_STOP_GRANT, LP_SLEEP, LP_DEEP} lp_e;

  typedef struct packed {
    logic hot_deassert_irq_en;
    logic hot_assert_irq_en;
    logic force_clock_mod;
    logic perf_en;
    logic clk_mod_en;
  } ctrl_s;
  localparam int CTRL_W = $bits(ctrl_s);
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  typedef struct packed {
    logic thr2_en;
    logic [6:0] thr2;
    logic thr1_en;
    logic [6:0] thr1;
  } thresh_s;
  localparam int THRESH_W = $bits(thresh_s);
  localparam logic [THRESH_W-1:0] THRESH_RESET = 16'h0000;

  typedef struct packed {
    logic oos;
    logic trip;
    logic thr2_cross;
    logic thr1_cross;
    logic [6:0] offset;
  } sense_s;

endpackage : thermal_pkg

// ===== core/clkmod_gen.sv
// Fixed half-on, half-off enable pattern for core clock gating.
// Assumes run is a level from the pclk domain.
module clkmod_gen #(
  parameter int unsigned HALF = thermal_pkg::MOD_HALF_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic phase_on
);
  import thermal_pkg::*;

  logic [7:0] cnt;

  // ==========================================================
  // Divider: phase flips every HALF cycles while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      phase_on <= 1'b1;
    end else if (!run) begin
      cnt <= 8'h00;
      phase_on <= 1'b1;
    end else if (cnt == 8'(HALF - 1)) begin
      cnt <= 8'h00;
      phase_on <= ~phase_on;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  chk_half_period: assert property (@(posedge pclk) disable iff (!presetn)
    run && cnt != 8'(HALF - 1) |=> $stable(phase_on) || !$past(run))
    else $error("clock modulation phase flipped early");

endmodule : clkmod_gen

// ===== core/core_sense.sv
// One core's digital sensor front end: offset, trip, thresholds, out-of-spec.
// Assumes temp is a synchronous absolute code in degrees.
module core_sense #(
  parameter int unsigned OOS_LIMIT = thermal_pkg::OOS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] temp,
  input wire thermal_pkg::thresh_s thresh,
  input wire logic throttling,
  output thermal_pkg::sense_s sense
);
  import thermal_pkg::*;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [6:0] offset_now;
  logic above1;
  logic above2;
  logic [15:0] hot_cnt;

  // ==========================================================
  // Offset below max, saturating at zero
  always_comb begin
    if (temp >= TJ_MAX) begin
      offset_now = 7'h00;
    end else begin
      offset_now = 7'(TJ_MAX - temp);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense.offset <= 7'h00;
    end else begin
      sense.offset <= offset_now;
    end
  end

  // Small hysteresis keeps the trip from chattering near max
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense.trip <= 1'b0;
    end else if (offset_now == 7'h00) begin
      sense.trip <= 1'b1;
    end else if (offset_now >= TRIP_HYST) begin
      sense.trip <= 1'b0;
    end
  end

  // ==========================================================
  // Threshold crossing in either direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      above1 <= 1'b0;
      above2 <= 1'b0;
      sense.thr1_cross <= 1'b0;
      sense.thr2_cross <= 1'b0;
    end else begin
      above1 <= offset_now <= thresh.thr1;
      above2 <= offset_now <= thresh.thr2;
      sense.thr1_cross <= thresh.thr1_en & ((offset_now <= thresh.thr1) != above1);
      sense.thr2_cross <= thresh.thr2_en & ((offset_now <= thresh.thr2) != above2);
    end
  end

  // ==========================================================
  // Out of spec: throttled yet still at the trip for OOS_LIMIT cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hot_cnt <= 16'h0000;
      sense.oos <= 1'b0;
    end else if (throttling && sense.trip) begin
      if (hot_cnt != 16'(OOS_LIMIT - 1)) begin
        hot_cnt <= hot_cnt + 16'h0001;
      end
      sense.oos <= hot_cnt == 16'(OOS_LIMIT - 1);
    end else begin
      hot_cnt <= 16'h0000;
      sense.oos <= 1'b0;
    end
  end

  chk_trip_at_max: assert property (offset_now == 7'h00 |=> sense.trip)
    else $error("trip missing at max temperature");
  chk_offset_sat: assert property (temp >= TJ_MAX |=> sense.offset == 7'h00)
    else $error("offset not saturated at max");
  chk_oos_clear: assert property (!(throttling && sense.trip) |=> !sense.oos)
    else $error("out of spec without hot throttling");
  chk_thr_cross: assert property (
    thresh.thr1_en && ((offset_now <= thresh.thr1) != above1) |=> sense.thr1_cross)
    else $error("threshold crossing missed");

endmodule : core_sense

// ===== core/die_thermal_sense.sv
// Die thermal sensing, throttle steering and shared hot pin, APB registers.
// Assumes pins and low-power state are synchronous to pclk.
//
// Design decisions made here: register access over APB and the address map.
module die_thermal_sense #(
  parameter int unsigned OOS_LIMIT = thermal_pkg::OOS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] core0_temp,
  input wire logic [7:0] core1_temp,
  input wire thermal_pkg::lp_e lp_state,
  input wire logic hot_throttle_pin_n_in,
  output logic hot_throttle_pin_n_out,
  output logic hot_throttle_pin_n_oe,
  output logic thermal_control_circuit_active,
  output logic perf_state_throttle,
  output logic [1:0] core_clk_run,
  output logic [1:0] core_irq
);
  import thermal_pkg::*;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [7:0] core_temp [NUM_CORES];
  ctrl_s ctrl;
  thresh_s thresh [NUM_CORES];
  sense_s sense [NUM_CORES];
  logic [31:0] sense_word [NUM_CORES];
  logic [NUM_CORES-1:0] trip;
  logic [NUM_CORES-1:0] oos_d;
  logic [NUM_CORES-1:0] oos_sticky;
  logic [NUM_CORES-1:0] thr1_sticky;
  logic [NUM_CORES-1:0] thr2_sticky;
  logic [NUM_CORES-1:0] gate_req;
  logic hot_level;
  logic hot_level_d;
  logic hot_rise_sticky;
  logic hot_fall_sticky;
  logic hot_edge_irq;
  logic ext_hot;
  logic any_trip;
  logic lp_normal;
  logic phase_on;
  logic setup;
  logic wr_en;
  logic [31:0] hot_word;
  logic [31:0] next_prdata;
  logic next_slverr;

  assign core_temp[0] = core0_temp;
  assign core_temp[1] = core1_temp;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;
  assign lp_normal = lp_state == LP_NORMAL;
  assign any_trip = |trip;

  // ==========================================================
  // Pin sensing: own drive is known, so a low seen without it is external
  assign hot_level = ~hot_throttle_pin_n_in;
  assign ext_hot = hot_level & ~hot_throttle_pin_n_oe;
  assign hot_edge_irq = (ctrl.hot_assert_irq_en & hot_level & ~hot_level_d)
    | (ctrl.hot_deassert_irq_en & ~hot_level & hot_level_d);

  // ==========================================================
  // APB slave: zero wait, data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= next_prdata;
      pslverr <= next_slverr;
    end else begin
      pslverr <= 1'b0;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr)
      CTRL_OFS: next_prdata[CTRL_W-1:0] = ctrl;
      SENSE_OFS[0]: next_prdata = sense_word[0];
      SENSE_OFS[1]: next_prdata = sense_word[1];
      THRESH_OFS[0]: next_prdata[THRESH_W-1:0] = thresh[0];
      THRESH_OFS[1]: next_prdata[THRESH_W-1:0] = thresh[1];
      HOTSTAT_OFS: next_prdata = hot_word;
      default: next_slverr = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ctrl_s'(CTRL_RESET);
    end else if (wr_en && paddr == CTRL_OFS) begin
      ctrl <= ctrl_s'(pwdata[CTRL_W-1:0]);
    end
  end

  always_comb begin
    hot_word = 32'h0000_0000;
    hot_word[HOT_LEVEL_BIT] = hot_level;
    hot_word[HOT_EXT_BIT] = ext_hot;
    hot_word[HOT_RISE_BIT] = hot_rise_sticky;
    hot_word[HOT_FALL_BIT] = hot_fall_sticky;
    hot_word[HOT_OWN_BIT] = hot_throttle_pin_n_oe;
    hot_word[HOT_PERF_BIT] = perf_state_throttle;
    hot_word[HOT_GATE_BIT +: NUM_CORES] = gate_req;
  end

  // ==========================================================
  // Per-core sensing, thresholds and sticky status
  for (genvar i = 0; i < NUM_CORES; i++) begin : g_core
    core_sense #(
      .OOS_LIMIT(OOS_LIMIT)
    ) u_sense (
      .pclk(pclk),
      .presetn(presetn),
      .temp(core_temp[i]),
      .thresh(thresh[i]),
      .throttling(gate_req[i] | perf_state_throttle),
      .sense(sense[i])
    );

    assign trip[i] = sense[i].trip;

    always_comb begin
      sense_word[i] = 32'h0000_0000;
      sense_word[i][6:0] = sense[i].offset;
      sense_word[i][SENSE_VALID_BIT] = lp_normal;
      sense_word[i][SENSE_TRIP_BIT] = sense[i].trip;
      sense_word[i][SENSE_OOS_BIT] = sense[i].oos;
      sense_word[i][SENSE_OOS_STICKY_BIT] = oos_sticky[i];
      sense_word[i][SENSE_THR1_STICKY_BIT] = thr1_sticky[i];
      sense_word[i][SENSE_THR2_STICKY_BIT] = thr2_sticky[i];
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        thresh[i] <= thresh_s'(THRESH_RESET);
      end else if (wr_en && paddr == THRESH_OFS[i]) begin
        thresh[i] <= thresh_s'(pwdata[THRESH_W-1:0]);
      end
    end

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        oos_d[i] <= 1'b0;
        oos_sticky[i] <= 1'b0;
        thr1_sticky[i] <= 1'b0;
        thr2_sticky[i] <= 1'b0;
      end else begin
        oos_d[i] <= sense[i].oos;
        if (sense[i].oos && !oos_d[i]) begin
          oos_sticky[i] <= 1'b1;
        end else if (wr_en && paddr == SENSE_OFS[i] && pwdata[SENSE_OOS_STICKY_BIT]) begin
          oos_sticky[i] <= 1'b0;
        end
        if (sense[i].thr1_cross) begin
          thr1_sticky[i] <= 1'b1;
        end else if (wr_en && paddr == SENSE_OFS[i] && pwdata[SENSE_THR1_STICKY_BIT]) begin
          thr1_sticky[i] <= 1'b0;
        end
        if (sense[i].thr2_cross) begin
          thr2_sticky[i] <= 1'b1;
        end else if (wr_en && paddr == SENSE_OFS[i] && pwdata[SENSE_THR2_STICKY_BIT]) begin
          thr2_sticky[i] <= 1'b0;
        end
      end
    end

    // Interrupt pulse to this core's interrupt controller
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        core_irq[i] <= 1'b0;
      end else begin
        core_irq[i] <= sense[i].thr1_cross | sense[i].thr2_cross
          | (sense[i].oos & ~oos_d[i]) | hot_edge_irq;
      end
    end

    // Clock gate request: external hot never uses forced modulation
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gate_req[i] <= 1'b0;
      end else begin
        gate_req[i] <= ctrl.clk_mod_en
          & ((trip[i] & (~ctrl.perf_en | ctrl.force_clock_mod))
          | (ext_hot & ~ctrl.perf_en));
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        core_clk_run[i] <= 1'b1;
      end else begin
        core_clk_run[i] <= ~(gate_req[i] & ~phase_on);
      end
    end
  end

  clkmod_gen #(
    .HALF(MOD_HALF_CYCLES)
  ) u_clkmod (
    .pclk(pclk),
    .presetn(presetn),
    .run(|gate_req),
    .phase_on(phase_on)
  );

  // ==========================================================
  // Hot pin edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hot_level_d <= 1'b0;
      hot_rise_sticky <= 1'b0;
      hot_fall_sticky <= 1'b0;
    end else begin
      hot_level_d <= hot_level;
      if (hot_level && !hot_level_d) begin
        hot_rise_sticky <= 1'b1;
      end else if (wr_en && paddr == HOTSTAT_OFS && pwdata[HOT_RISE_BIT]) begin
        hot_rise_sticky <= 1'b0;
      end
      if (!hot_level && hot_level_d) begin
        hot_fall_sticky <= 1'b1;
      end else if (wr_en && paddr == HOTSTAT_OFS && pwdata[HOT_FALL_BIT]) begin
        hot_fall_sticky <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Open-drain drive: only low is ever driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hot_throttle_pin_n_out <= 1'b0;
      hot_throttle_pin_n_oe <= 1'b0;
    end else begin
      hot_throttle_pin_n_out <= 1'b0;
      if (lp_normal) begin
        hot_throttle_pin_n_oe <= any_trip;
      end
      // Outside normal state the drive only holds, never starts
    end
  end

  // ==========================================================
  // Throttle steering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perf_state_throttle <= 1'b0;
      thermal_control_circuit_active <= 1'b0;
    end else begin
      perf_state_throttle <= ctrl.perf_en & (any_trip | ext_hot);
      thermal_control_circuit_active <= (hot_level | any_trip)
        & (ctrl.clk_mod_en | ctrl.perf_en);
    end
  end

  chk_hot_drive: assert property (lp_normal && any_trip |=> hot_throttle_pin_n_oe)
    else $error("hot pin not driven on trip");
  chk_hot_hold: assert property (
    !hot_throttle_pin_n_oe && !lp_normal |=> !hot_throttle_pin_n_oe)
    else $error("hot pin newly driven in low power state");
  chk_tcc_active: assert property (
    hot_level && (ctrl.clk_mod_en || ctrl.perf_en) |=> thermal_control_circuit_active)
    else $error("thermal control idle while hot");
  chk_ext_perf: assert property (ext_hot && ctrl.perf_en |=> perf_state_throttle)
    else $error("external hot did not lower perf state");
  chk_force_ignored: assert property (
    ext_hot && !any_trip && ctrl.perf_en |=> gate_req == 2'b00)
    else $error("forced modulation applied on external hot");
  chk_ext_both: assert property (
    ext_hot && ctrl.clk_mod_en && !ctrl.perf_en |=> gate_req == 2'b11)
    else $error("external hot did not gate both cores");
  chk_trip_local: assert property (
    trip == 2'b01 && !ext_hot && ctrl.clk_mod_en && !ctrl.perf_en
    |=> gate_req == 2'b01)
    else $error("clock gating not limited to tripped core");
  chk_edge_irq: assert property (
    ctrl.hot_assert_irq_en && hot_level && !hot_level_d |=> core_irq == 2'b11)
    else $error("hot assertion interrupt missing");
  chk_perf_trip: assert property (trip[1] && ctrl.perf_en |=> perf_state_throttle)
    else $error("internal trip did not lower perf state");
  chk_apb_ready: assert property (setup |=> pready ##1 !pready)
    else $error("apb ready timing wrong");

  // ==========================================================
  // Release, error, interrupt, sticky and perf gating checks
  chk_slverr_map: assert property (setup && next_slverr |=> pready && pslverr)
    else $error("unmapped access not flagged");
  chk_hot_release: assert property (lp_normal && !any_trip |=> !hot_throttle_pin_n_oe)
    else $error("hot pin held after cooling");
  chk_fall_irq: assert property (
    ctrl.hot_deassert_irq_en && !hot_level && hot_level_d |=> core_irq == 2'b11)
    else $error("hot deassertion interrupt missing");
  chk_oos_sticky: assert property (sense[0].oos && !oos_d[0] |=> oos_sticky[0])
    else $error("out of spec sticky not latched");
  chk_perf_nogate: assert property (
    ctrl.perf_en && !ctrl.force_clock_mod && !ext_hot |=> gate_req == 2'b00)
    else $error("clock gated under perf throttling");

endmodule : die_thermal_sense

// ===== verif/hot_monitor.sv
// Model of an external thermal monitor sharing the hot pin.
// Assumes a pull-up on the pin and an open-drain device driver.
module hot_monitor (
  input wire logic pclk,
  input wire logic req,
  input wire logic dev_oe,
  output logic pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drive;
  // ======
  // Drive
  always_ff @(posedge pclk) begin
    drive <= req;
  end
  // Wired low over the pull-up, so released reads high
  assign pin_n = (dev_oe || drive) ? 1'b0 : 1'b1;
endmodule : hot_monitor

// ===== verif/die_thermal_sense_tb.sv
// Self-checking bench for the die thermal block.
// Assumes the APB master here and the hot monitor model on the pin.
module die_thermal_sense_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import thermal_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, req = 1'b0;
  logic [7:0] paddr = 8'h00, t0 = 8'h00, t1 = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, oe, pout, thermal_control_circuit, perf, pin_n;
  logic [1:0] run, irq;
  lp_e lp = LP_NORMAL;
  int failures = 0, n_checks = 0, ic[2] = '{0, 0}, oc[2] = '{0, 0}, i0[2], o0[2];

  always #50 pclk = ~pclk;

  die_thermal_sense #(.OOS_LIMIT(8)) die_thermal_sense_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core0_temp(t0), .core1_temp(t1),
    .lp_state(lp), .hot_throttle_pin_n_in(pin_n), .hot_throttle_pin_n_out(pout),
    .hot_throttle_pin_n_oe(oe), .thermal_control_circuit_active(thermal_control_circuit),
    .perf_state_throttle(perf), .core_clk_run(run), .core_irq(irq));
  hot_monitor hot_monitor_i (.pclk(pclk), .req(req), .dev_oe(oe), .pin_n(pin_n));

  // ======
  // Pulse and gate counters
  always @(posedge pclk) begin
    for (int c = 0; c < 2; c++) begin
      ic[c] <= ic[c] + int'(irq[c] === 1'b1);
      oc[c] <= oc[c] + int'(run[c] === 1'b0);
    end
  end

  // ======
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Waits for pready as long as it takes; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic snap();
    i0 = ic;
    o0 = oc;
  endtask : snap

  function automatic logic [31:0] irqd();
    return {16'(ic[0] - i0[0]), 16'(ic[1] - i0[1])};
  endfunction : irqd

  function automatic logic [31:0] offd();
    return {16'(oc[0] - o0[0]), 16'(oc[1] - o0[1])};
  endfunction : offd

  // Valid bit over offset below the maximum, saturating at zero
  function automatic logic [7:0] exp_sense(input logic [7:0] t);
    return {1'b1, (t >= TJ_MAX) ? 7'h00 : 7'(TJ_MAX - t)};
  endfunction : exp_sense

  task automatic summarize();
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // ======
  // Watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    summarize();
  end

  // ======
  // Sequence
  initial begin
    void'($urandom(32'hd7b04080));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    chk("reset outs", 32'h03, {oe, thermal_control_circuit, perf, run});
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
    for (int i = 0; i < 8; i++) begin
      t0 <= 8'($urandom_range(97));
      t1 <= (i == 0) ? 8'h00 : 8'($urandom_range(97));
      cyc(3);
      apb(1'b0, SENSE_OFS[0], 32'h0);
      chk("sense0", {24'h0, exp_sense(t0)}, {24'h0, rd[8], rd[6:0]});
      apb(1'b0, SENSE_OFS[1], 32'h0);
      chk("sense1", {24'h0, exp_sense(t1)}, {24'h0, rd[8], rd[6:0]});
    end
    apb(1'b1, THRESH_OFS[0], 32'h8a);
    apb(1'b1, THRESH_OFS[1], 32'h8a00);
    t0 <= 8'h55;
    t1 <= 8'h55;
    cyc(4);
    snap();
    t0 <= 8'h5f;
    t1 <= 8'h5f;
    cyc(5);
    chk("thr irq", 32'h0001_0001, irqd());
    apb(1'b1, THRESH_OFS[0], 32'h0);
    apb(1'b1, THRESH_OFS[1], 32'h0);
    apb(1'b1, CTRL_OFS, 32'h1);
    snap();
    t0 <= 8'h78;
    cyc(40);
    chk("trip outs", 32'hc, {oe, thermal_control_circuit, perf, pin_n});
    chk("pin drive", 32'h0, 32'(pout));
    chk("oos irq", 32'h0001_0000, irqd());
    snap();
    cyc(32);
    chk("own gate", 32'h0010_0000, offd());
    apb(1'b0, SENSE_OFS[0], 32'h0);
    chk("oos bits", 32'h380, {rd[18:16], rd[6:0]});
    apb(1'b0, HOTSTAT_OFS, 32'h0);
    chk("own drive", 32'h5, {rd[4], rd[1], rd[0]});
    t0 <= 8'h50;
    cyc(6);
    chk("cool outs", 32'h03, {oe, thermal_control_circuit, perf, run});
    apb(1'b0, SENSE_OFS[0], 32'h0);
    chk("sticky", 32'h6, rd[19:17]);
    apb(1'b1, SENSE_OFS[0], 32'h1c_0000);
    apb(1'b0, SENSE_OFS[0], 32'h0);
    chk("sticky clr", 32'h0, rd[20:18]);
    apb(1'b1, CTRL_OFS, 32'h2);
    t1 <= 8'h64;
    cyc(6);
    snap();
    cyc(16);
    chk("perf outs", 32'h7, {oe, thermal_control_circuit, perf});
    chk("perf no gate", 32'h0, offd());
    t1 <= 8'h50;
    apb(1'b1, CTRL_OFS, 32'h9);
    apb(1'b1, HOTSTAT_OFS, 32'hc);
    cyc(6);
    snap();
    req <= 1'b1;
    cyc(4);
    chk("ext outs", 32'h2, {oe, thermal_control_circuit, perf});
    chk("rise irq", 32'h0001_0001, irqd());
    apb(1'b0, HOTSTAT_OFS, 32'h0);
    chk("ext seen", 32'h3, {rd[4], rd[3], rd[2], rd[1]});
    snap();
    cyc(32);
    chk("ext gate", 32'h0010_0010, offd());
    apb(1'b1, CTRL_OFS, 32'h17);
    cyc(6);
    snap();
    cyc(16);
    chk("ext perf", 32'h3, {oe, thermal_control_circuit, perf});
    chk("force off", 32'h0, offd());
    snap();
    req <= 1'b0;
    cyc(4);
    chk("fall irq", 32'h0001_0001, irqd());
    chk("ext off", 32'h0, {thermal_control_circuit, perf});
    lp <= LP_STOP_GRANT;
    t0 <= 8'h64;
    cyc(6);
    chk("lp no drive", 32'h0, 32'(oe));
    apb(1'b0, SENSE_OFS[0], 32'h0);
    chk("lp valid", 32'h0, 32'(rd[8]));
    lp <= LP_NORMAL;
    cyc(4);
    lp <= LP_SLEEP;
    t0 <= 8'h50;
    cyc(6);
    chk("lp held", 32'h1, 32'(oe));
    lp <= LP_NORMAL;
    cyc(4);
    chk("lp exit", 32'h0, 32'(oe));
    summarize();
  end
endmodule : die_thermal_sense_tb
